// File: verilog/pos_steer.sv
// PWM output steering stage with Wishbone register access
// Operation
// - Four enable bits: A0, B1, C2, D3
// - Enabled pin carries PWM with mode polarity
// - Disabled pin returns to port logic
// - Steering only in single-output configuration 00
//
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pos_map.svh"

// One steered pin; registered so a pin never glitches on a mux change
module pos_pin_cell import pos_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic steer_i,
  input wire logic wave_i,
  input wire logic port_i,
  output logic pin_o
);
  logic pin_q, pin_d;

  always_comb begin
    pin_d = port_i;
    if (steer_i) begin
      pin_d = wave_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_q <= `POS_PIN_RST;
    end else begin
      pin_q <= pin_d;
    end
  end

  assign pin_o = pin_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_cell_wave: assert property (steer_i |=> pin_o == $past(wave_i))
    else $error("steered pin lost the wave");
  a_cell_port: assert property (!steer_i |=> pin_o == $past(port_i))
    else $error("released pin lost the port level");
endmodule : pos_pin_cell

module pos_steer import pos_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic pwm_i,
  input wire logic period_start_i,
  input wire logic [3:0] port_dat_i,
  output logic [3:0] pin_o
);
  pos_steer_t ctl_q, ctl_d;
  pos_mode_t mode_q, mode_d;
  logic [3:0] act_q, act_d;
  logic [3:0] div_q, div_d;
  logic ack_q, ack_d;
  logic [31:0] rd_q, rd_d;
  logic [3:0] steer_on;
  logic [3:0] pin_cell;
  logic instr_tick;
  logic wave;
  logic wr, lane0;
  logic hit_steer, hit_mode, hit_status;

  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;
  assign lane0 = wb_sel_i[0];

  // Address decode, shared by write enables and read mux
  assign hit_steer = (wb_adr_i == `POS_ADDR_STEER);
  assign hit_mode = (wb_adr_i == `POS_ADDR_MODE);
  assign hit_status = (wb_adr_i == `POS_ADDR_STATUS);

  // Acknowledge: one pulse per request, unmapped addresses included
  always_comb begin
    ack_d = wb_cyc_i && wb_stb_i && !ack_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
    end
  end

  // Steering register; only byte lane 0 carries live bits
  always_comb begin
    ctl_d = ctl_q;
    if (wr && lane0 && hit_steer) begin
      ctl_d = pos_steer_t'(wb_dat_i[4:0]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_q <= pos_steer_t'(`POS_STEER_RST);
    end else begin
      ctl_q <= ctl_d;
    end
  end

  // Mode register: polarity and output configuration
  always_comb begin
    mode_d = mode_q;
    if (wr && lane0 && hit_mode) begin
      mode_d = pos_mode_t'(wb_dat_i[3:0]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= pos_mode_t'(`POS_MODE_RST);
    end else begin
      mode_q <= mode_d;
    end
  end

  // Read mux; unused bits and unmapped addresses read as zero
  always_comb begin
    rd_d = 32'h0000_0000;
    if (hit_steer) begin
      rd_d = {27'h0, ctl_q};
    end else if (hit_mode) begin
      rd_d = {28'h0, mode_q};
    end else if (hit_status) begin
      rd_d = {28'h0, act_q};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_q <= 32'h0000_0000;
    end else begin
      rd_q <= rd_d;
    end
  end

  // Instruction-cycle divider, free running from reset
  // Boundary pulse once every four clocks
  assign instr_tick = (div_q == `POS_INSTR_DIV - 4'h1);

  always_comb begin
    div_d = instr_tick ? 4'h0 : div_q + 4'h1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q <= 4'h0;
    end else begin
      div_q <= div_d;
    end
  end

  // Staged update avoids runt pulses mid-period
  always_comb begin
    act_d = act_q;
    if (ctl_q.sync ? period_start_i : instr_tick) begin
      act_d = ctl_q.en;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_q <= `POS_ACT_RST;
    end else begin
      act_q <= act_d;
    end
  end

  // Polarity from mode bit 0; other configurations leave all pins to ports
  always_comb begin
    wave = pwm_i ^ mode_q.pol[0];
    for (int i = 0; i < 4; i++) begin
      steer_on[i] = (mode_q.cfg == `POS_CFG_SINGLE) && act_q[i];
    end
  end

  pos_pin_cell pos_pin_cell_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .steer_i(steer_on[`POS_BIT_EN_A]),
    .wave_i(wave),
    .port_i(port_dat_i[`POS_BIT_EN_A]),
    .pin_o(pin_cell[`POS_BIT_EN_A])
  );

  pos_pin_cell pos_pin_cell_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .steer_i(steer_on[`POS_BIT_EN_B]),
    .wave_i(wave),
    .port_i(port_dat_i[`POS_BIT_EN_B]),
    .pin_o(pin_cell[`POS_BIT_EN_B])
  );

  pos_pin_cell pos_pin_cell_c (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .steer_i(steer_on[`POS_BIT_EN_C]),
    .wave_i(wave),
    .port_i(port_dat_i[`POS_BIT_EN_C]),
    .pin_o(pin_cell[`POS_BIT_EN_C])
  );

  pos_pin_cell pos_pin_cell_d (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .steer_i(steer_on[`POS_BIT_EN_D]),
    .wave_i(wave),
    .port_i(port_dat_i[`POS_BIT_EN_D]),
    .pin_o(pin_cell[`POS_BIT_EN_D])
  );

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rd_q;
  assign pin_o = pin_cell;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_pin_port: assert property (!act_q[1] |=> pin_o[1] == $past(port_dat_i[1]))
    else $error("disabled pin b not port data");
  a_pin_pwm: assert property (act_q[0] && mode_q.cfg == 2'h0 |=> pin_o[0] == ($past(pwm_i) ^ $past(mode_q.pol[0])))
    else $error("enabled pin a not pwm");
  a_cfg_block: assert property (mode_q.cfg != 2'h0 |=> pin_o == $past(port_dat_i))
    else $error("steering outside single mode");
  a_sync_hold: assert property (ctl_q.sync && !period_start_i |=> act_q == $past(act_q))
    else $error("sync update off period");
  a_sync_take: assert property (ctl_q.sync && period_start_i |=> act_q == $past(ctl_q.en))
    else $error("period update missed");
  a_tick_take: assert property (!ctl_q.sync && instr_tick |=> act_q == $past(ctl_q.en))
    else $error("instruction update missed");
  a_write_en: assert property (wr && lane0 && wb_adr_i == 8'h00 |=> ctl_q.en == $past(wb_dat_i[3:0]))
    else $error("enable write lost");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");

  // Per-pin routing
  a_pin_a_port: assert property (!act_q[0] |=> pin_o[0] == $past(port_dat_i[0]))
    else $error("disabled pin a not port data");
  a_pin_b_pwm: assert property (act_q[1] && mode_q.cfg == 2'h0 |=> pin_o[1] == ($past(pwm_i) ^ $past(mode_q.pol[0])))
    else $error("enabled pin b not pwm");
  a_pin_c_port: assert property (!act_q[2] |=> pin_o[2] == $past(port_dat_i[2]))
    else $error("disabled pin c not port data");
  a_pin_c_pwm: assert property (act_q[2] && mode_q.cfg == 2'h0 |=> pin_o[2] == ($past(pwm_i) ^ $past(mode_q.pol[0])))
    else $error("enabled pin c not pwm");
  a_pin_d_port: assert property (!act_q[3] |=> pin_o[3] == $past(port_dat_i[3]))
    else $error("disabled pin d not port data");
  a_pin_d_pwm: assert property (act_q[3] && mode_q.cfg == 2'h0 |=> pin_o[3] == ($past(pwm_i) ^ $past(mode_q.pol[0])))
    else $error("enabled pin d not pwm");

  // Update timing
  a_tick_hold: assert property (!ctl_q.sync && !instr_tick |=> act_q == $past(act_q))
    else $error("update between instruction ticks");
  a_tick_spacing: assert property (instr_tick |=> !instr_tick)
    else $error("instruction ticks back to back");

  // Register bus
  a_write_sync: assert property (wr && lane0 && wb_adr_i == 8'h00 |=> ctl_q.sync == $past(wb_dat_i[4]))
    else $error("sync write lost");
  a_write_mode: assert property (wr && lane0 && wb_adr_i == 8'h04 |=> mode_q == $past(wb_dat_i[3:0]))
    else $error("mode write lost");
  a_lane_off: assert property (wb_cyc_i && wb_stb_i && wb_we_i && !wb_sel_i[0] |=> ctl_q == $past(ctl_q))
    else $error("write without lane 0 took effect");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered");
  a_ack_idle: assert property (!wb_cyc_i |=> !wb_ack_o)
    else $error("ack without request");
  a_status_read: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && hit_status |=> wb_dat_o == {28'h0, $past(act_q)})
    else $error("status read wrong");
  a_steer_read: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && hit_steer |=> wb_dat_o == {27'h0, $past(ctl_q)})
    else $error("steering read wrong");
  a_unmapped_zero: assert property (wb_cyc_i && wb_stb_i && !hit_steer && !hit_mode && !hit_status |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");

  c_sync: cover property (ctl_q.sync && period_start_i);
  c_tick: cover property (!ctl_q.sync && instr_tick && ctl_q.en != act_q);
  c_all: cover property (act_q == 4'hF && mode_q.cfg == 2'h0);
  c_invert: cover property (act_q[0] && mode_q.cfg == 2'h0 && mode_q.pol[0]);
  c_cfg_other: cover property (act_q != 4'h0 && mode_q.cfg != 2'h0);
endmodule : pos_steer
`default_nettype wire

// File: shared/pos_map.svh
// Register map and field positions of the PWM output steering block
`ifndef POS_MAP_SVH
`define POS_MAP_SVH
`define POS_ADDR_STEER 8'h00
`define POS_ADDR_MODE 8'h04
`define POS_ADDR_STATUS 8'h08
`define POS_BIT_EN_A 0
`define POS_BIT_EN_B 1
`define POS_BIT_EN_C 2
`define POS_BIT_EN_D 3
`define POS_BIT_SYNC 4
`define POS_STEER_RST 5'h01
`define POS_ACT_RST 4'h1
`define POS_PIN_RST 1'b0
`define POS_MODE_RST 4'h0
`define POS_CFG_SINGLE 2'h0
`define POS_INSTR_DIV 4'h4
`endif

// File: shared/pos_pkg.sv
// Types of the PWM output steering block
package pos_pkg;
  typedef struct packed {
    logic sync;
    logic [3:0] en;
  } pos_steer_t;
  typedef struct packed {
    logic [1:0] cfg;
    logic [1:0] pol;
  } pos_mode_t;
endpackage : pos_pkg

// File: bench/pos_load.sv
// Loads on the four steered pins
`timescale 1ns/1ps
`default_nettype none
module pos_load (
  input wire logic clk_i,
  input wire logic [3:0] pin_i,
  output logic [3:0] seen_o
);
  // Pure loads: they sample and never drive back
  always_ff @(posedge clk_i) seen_o <= pin_i;
endmodule : pos_load
`default_nettype wire

// File: bench/pos_steer_tb.sv
// Bench of the PWM output steering stage
`timescale 1ns/1ps
`default_nettype none
module pos_steer_tb;
  import pos_pkg::*;
  logic clk_i = 0, rst_i = 1, we = 0, cyc = 0, pwm = 0, ps = 0, ack;
  logic [7:0] adr = 0;
  logic [31:0] wd = 0, rd, r;
  logic [3:0] port = 0, pin, seen, old = 4'h1, sel = 4'hF;
  int failures = 0, samples_checked = 0, seed = 32'hc0d9, en, md;
  always #2.5 clk_i = ~clk_i;
  pos_steer pos_steer_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wd),
    .wb_dat_o(rd), .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_ack_o(ack), .pwm_i(pwm), .period_start_i(ps), .port_dat_i(port), .pin_o(pin));
  pos_load pos_load_inst (.clk_i(clk_i), .pin_i(pin), .seen_o(seen));
  task chk(input logic [31:0] a, input logic [31:0] b);
    samples_checked++;
    if (a !== b) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, a, b);
    end
  endtask : chk
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] o);
    @(posedge clk_i);
    adr <= a;
    wd <= d;
    we <= w;
    cyc <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    o = rd;
    cyc <= 1'b0;
  endtask : wb
  task pins(input logic [3:0] act, input logic [3:0] m);
    logic [3:0] e;
    for (int i = 0; i < 4; i++) e[i] = (act[i] && m[3:2] == 2'h0) ? pwm ^ m[0] : port[i];
    chk({28'h0, pin}, {28'h0, e});
    chk({28'h0, seen}, {28'h0, e});
  endtask : pins
  task summarize;
    if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  initial begin
    #50000;
    failures++;
    summarize;
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h00, 32'h0, r);
    chk(r, 32'h01);
    wb(1'b0, 8'h0C, 32'h0, r);
    chk(r, 32'h0);
    sel <= 4'hE;
    wb(1'b1, 8'h00, 32'h1E, r);
    sel <= 4'hF;
    wb(1'b0, 8'h00, 32'h0, r);
    chk(r, 32'h01);
    for (int k = 0; k < 24; k++) begin
      en = $random(seed);
      md = $random(seed);
      port <= en[7:4];
      pwm <= md[4];
      wb(1'b1, 8'h04, {28'h0, md[3:0]}, r);
      wb(1'b1, 8'h00, {27'h0, k[0], en[3:0]}, r);
      repeat (8) @(posedge clk_i);
      // Sync set: the active enables hold until the period pulse
      if (k[0]) begin
        pins(old, md[3:0]);
        ps <= 1'b1;
        @(posedge clk_i);
        ps <= 1'b0;
        repeat (3) @(posedge clk_i);
      end
      wb(1'b0, 8'h08, 32'h0, r);
      chk(r, {28'h0, en[3:0]});
      wb(1'b0, 8'h04, 32'h0, r);
      chk(r, {28'h0, md[3:0]});
      pins(en[3:0], md[3:0]);
      old = en[3:0];
    end
    summarize;
  end
endmodule : pos_steer_tb
`default_nettype wire
